/* verilog/rsw_receiver.sv */
// Purpose: Receive a serial control word, check it, dispatch it to a module
// Assumes: Oscillator tick and bit clock are system-clock-domain strobes
// Notes:   Bit clock samples line bits in the middle of each cell
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module rsw_receiver #(
  parameter int BIT_CYC   = 5208,
  parameter int ALARM_LEN = rsw_pkg::ALARM_CYC,
  parameter logic [1:0] TERM_ADDR = 2'h0
) (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  // Line side
  input  wire logic                 lineIn,
  input  wire logic                 dataSetReadyIn,
  input  wire logic                 carrierOnIn,
  input  wire logic                 oscillatorTick,
  // Module side
  input  wire rsw_pkg::rsw_status_t moduleStatus,
  input  wire logic                 conversionComplete,
  input  wire logic                 scannerConverting,
  input  wire logic [12:0]          panelData,
  output logic [2:0]                moduleAddressBuffer,
  output logic [12:0]               moduleDataOut,
  output logic                      phaseAPulse,
  output logic                      phaseBPulse,
  output logic                      simOutCmd,
  output logic                      simInCmd,
  output logic                      stallAlarm,
  output logic                      errorFlag,
  // Register port
  input  wire logic [3:0]           regAddr,
  input  wire logic [31:0]          regWdata,
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  output logic [31:0]               regRdata
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  localparam int SHIFT_BITS_W = rsw_pkg::SHIFT_BITS;   // Data, parity and first stop
  localparam int PH_CYC       = rsw_pkg::PHASE_CYC;    // Cycles in each phase pulse
  rsw_pkg::rsw_state_t state_r;            // Sequencer state
  logic [2:0]  lineSync_r;                 // Line synchroniser
  logic [2:0]  dsrSync_r;                  // DSR synchroniser
  logic [2:0]  cdSync_r;                   // Carrier synchroniser
  logic        lineLvl_r;                  // Filtered line level
  logic        dsrLvl_r;                   // Filtered DSR
  logic        cdLvl_r;                    // Filtered carrier
  logic        firstBitFlag_r;             // Start seen
  logic        wordEnable_r;               // Receiving a word
  logic        controlWordHere_r;          // Word complete
  logic        terminalSelected_r;         // Terminal address matched
  logic        parityFlop_r;               // Running parity
  logic [SHIFT_BITS_W-1:0] shift_r;        // Receive register
  logic [4:0]  bitCount_r;                 // Bits still to shift
  logic [15:0] baud_r;                     // Cell timer
  logic [15:0] phase_r;                    // Phase pulse timer
  logic [6:0]  selDly_r;                   // Select delay timer
  logic [31:0] alarm_r;                    // Stall alarm timer
  logic [31:0] ctrl_r;                     // Control register
  logic        bitClock;                   // Sample strobe
  logic        loadAddressBuffer;          // Address load moment
  logic        selectedModuleReady;        // Addressed module ready
  logic        phaseAEnable;               // Phase A start term
  logic        online;
  logic        manual;
  logic        alarmSet;
  logic [18:0] response;                   // Response word image

  assign online = ctrl_r[rsw_pkg::CTRL_ONLINE];
  assign manual = ctrl_r[rsw_pkg::CTRL_MANUAL];

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: a change counts when stages two and three agree
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      lineSync_r <= 3'h7;
      dsrSync_r  <= 3'h0;
      cdSync_r   <= 3'h0;
      lineLvl_r  <= 1'b1;
      dsrLvl_r   <= 1'b0;
      cdLvl_r    <= 1'b0;
    end
    else
    begin
      lineSync_r <= {lineSync_r[1:0], lineIn};
      dsrSync_r  <= {dsrSync_r[1:0], dataSetReadyIn};
      cdSync_r   <= {cdSync_r[1:0], carrierOnIn};
      if (lineSync_r[1] == lineSync_r[2])
        lineLvl_r <= lineSync_r[2];
      if (dsrSync_r[1] == dsrSync_r[2])
        dsrLvl_r <= dsrSync_r[2];
      if (cdSync_r[1] == cdSync_r[2])
        cdLvl_r <= cdSync_r[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit clock: runs only while word enable holds, half cell offset
  // word enable gates clock
  assign bitClock = wordEnable_r && (baud_r == 16'(BIT_CYC - 1));

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      baud_r <= 16'h0000;
    else if (!wordEnable_r)
      baud_r <= 16'(BIT_CYC / 2);   // First sample lands mid start bit
    else if (bitClock)
      baud_r <= 16'h0000;
    else
      baud_r <= baud_r + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Derived terms
  assign loadAddressBuffer = (state_r == rsw_pkg::ST_CWH) && (selDly_r == 7'(rsw_pkg::SEL_DELAY_CYC));
  always_comb
  begin
    case (moduleAddressBuffer)
      rsw_pkg::ADR_MO_SHORT, rsw_pkg::ADR_MO_LONG: selectedModuleReady = moduleStatus.multiOutputReady;
      rsw_pkg::ADR_TO:                              selectedModuleReady = moduleStatus.timedOutputReady;
      default:                                      selectedModuleReady = moduleStatus.deviceReady;
    endcase
  end
  // OR path when idle, AND path when converting
  assign phaseAEnable = !scannerConverting || (conversionComplete && terminalSelected_r);

  ////////////////////////////////////////////////////////////////////////////
  // Receive sequencer
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r            <= rsw_pkg::ST_IDLE;
      firstBitFlag_r     <= 1'b0;
      wordEnable_r       <= 1'b0;
      controlWordHere_r  <= 1'b0;
      terminalSelected_r <= 1'b0;
      bitCount_r         <= 5'h00;
      selDly_r           <= 7'h00;
      phase_r            <= 16'h0000;
    end
    else
    begin
      firstBitFlag_r <= 1'b0;
      case (state_r)
        rsw_pkg::ST_IDLE:
        begin
          // set on tick with DSR and carrier
          if (!lineLvl_r && oscillatorTick && dsrLvl_r && cdLvl_r)
          begin
            firstBitFlag_r <= 1'b1;
            wordEnable_r   <= 1'b1;
            bitCount_r     <= 5'(SHIFT_BITS_W + 1);
            state_r        <= rsw_pkg::ST_SHIFT;
          end
        end
        rsw_pkg::ST_SHIFT:
        begin
          if (!cdLvl_r)
          begin
            wordEnable_r <= 1'b0;       // Carrier lost, word dropped
            state_r      <= rsw_pkg::ST_IDLE;
          end
          else if (bitClock && bitCount_r == 5'h01)
          begin
            wordEnable_r <= 1'b0;
            if (online)
            begin
              controlWordHere_r <= 1'b1;
              selDly_r          <= 7'h00;
              state_r           <= rsw_pkg::ST_CWH;
            end
            else
              state_r <= rsw_pkg::ST_IDLE;
          end
          else if (bitClock)
            bitCount_r <= bitCount_r - 5'h01;
        end
        rsw_pkg::ST_CWH:
        begin
          selDly_r <= selDly_r + 7'h01;
          if (loadAddressBuffer)
          begin
            if (shift_r[rsw_pkg::TERM_HI:rsw_pkg::TERM_LO] == TERM_ADDR)
            begin
              terminalSelected_r <= 1'b1;
              state_r            <= rsw_pkg::ST_WAIT;
            end
            else
            begin
              controlWordHere_r <= 1'b0;
              state_r           <= rsw_pkg::ST_IDLE;
            end
          end
        end
        rsw_pkg::ST_WAIT:
        begin
          if (selectedModuleReady && phaseAEnable)
          begin
            controlWordHere_r <= 1'b0;
            phase_r           <= 16'h0000;
            state_r           <= rsw_pkg::ST_PHA;
          end
        end
        rsw_pkg::ST_PHA:
        begin
          phase_r <= phase_r + 16'h0001;
          if (phase_r == 16'(PH_CYC - 1))
          begin
            phase_r <= 16'h0000;
            state_r <= rsw_pkg::ST_PHB;
          end
        end
        rsw_pkg::ST_PHB:
        begin
          phase_r <= phase_r + 16'h0001;
          if (phase_r == 16'(PH_CYC - 1))
          begin
            terminalSelected_r <= 1'b0;
            state_r            <= rsw_pkg::ST_IDLE;
          end
        end
        default:
          state_r <= rsw_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive register: LSB first, start bit sample is not shifted in
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      shift_r <= '0;
    else if (bitClock && bitCount_r != 5'(SHIFT_BITS_W + 1))
      shift_r <= {lineLvl_r, shift_r[SHIFT_BITS_W-1:1]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parity and error flops
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      parityFlop_r <= 1'b0;
      errorFlag    <= 1'b0;
    end
    else
    begin
      // clear on first bit, toggle on ones
      if (firstBitFlag_r)
        parityFlop_r <= 1'b0;
      else if (bitClock && lineLvl_r && bitCount_r != 5'(SHIFT_BITS_W + 1))
        parityFlop_r <= ~parityFlop_r;
      // even ones flagged at address load
      if ((state_r == rsw_pkg::ST_SHIFT && !cdLvl_r) || (loadAddressBuffer && parityFlop_r))
        errorFlag <= 1'b1;
      else if (firstBitFlag_r)
        errorFlag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address buffer and module outputs
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      moduleAddressBuffer <= 3'h0;
      moduleDataOut       <= 13'h1FFF;
    end
    else
    begin
      if (state_r == rsw_pkg::ST_CWH && !loadAddressBuffer)
        moduleAddressBuffer <= 3'h0;
      else if (loadAddressBuffer)
        moduleAddressBuffer <= shift_r[rsw_pkg::ADDR_HI:rsw_pkg::ADDR_LO];
      moduleDataOut <= manual ? panelData : ~shift_r[rsw_pkg::DATA_HI:0];
    end
  end

  assign phaseAPulse = (state_r == rsw_pkg::ST_PHA);
  assign phaseBPulse = (state_r == rsw_pkg::ST_PHB);
  // command chosen by address and converter
  // code 6 is analog plus digital input
  always_comb
  begin
    simOutCmd = 1'b0;
    simInCmd  = 1'b0;
    if (phaseAPulse || phaseBPulse)
    begin
      case (moduleAddressBuffer)
        rsw_pkg::ADR_DI, rsw_pkg::ADR_PBI, rsw_pkg::ADR_ADI: simInCmd = 1'b1;
        default: simOutCmd = !scannerConverting || moduleAddressBuffer != rsw_pkg::ADR_AO;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response word image
  always_comb
  begin
    response = 19'h00000;
    response[rsw_pkg::RDY_LO+2:rsw_pkg::RDY_LO] = {moduleStatus.multiOutputReady, moduleStatus.deviceReady,
                                                   moduleStatus.timedOutputReady};
    if (errorFlag || moduleAddressBuffer == rsw_pkg::ADR_MO_SHORT || moduleAddressBuffer == rsw_pkg::ADR_MO_LONG ||
        moduleAddressBuffer == rsw_pkg::ADR_AO || moduleAddressBuffer == rsw_pkg::ADR_TO ||
        moduleAddressBuffer == rsw_pkg::ADR_PBO)
    begin
      response[rsw_pkg::BIT_SCE] = moduleStatus.scannerErrorOut;
      response[rsw_pkg::BIT_COF] = moduleStatus.converterOverflowOut;
      response[rsw_pkg::BIT_ERR] = errorFlag;
    end
    else if (scannerConverting)
      response[rsw_pkg::CONV_LO+11:rsw_pkg::CONV_LO] = moduleStatus.converterData;
    else
      response[11:0] = moduleStatus.bufferData;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stall alarm: retriggerable one-shot
  // alarm only after full untouched cycle
  assign alarmSet = regWr && regAddr == rsw_pkg::REG_CTRL && regWdata[rsw_pkg::CTRL_ALARM];
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      alarm_r    <= 32'h00000000;
      stallAlarm <= 1'b0;
    end
    else if (alarmSet)
    begin
      alarm_r    <= 32'h00000000;
      stallAlarm <= 1'b0;
    end
    else if (alarm_r == 32'(ALARM_LEN - 1))
      stallAlarm <= 1'b1;
    else
      alarm_r <= alarm_r + 32'h00000001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_r   <= rsw_pkg::CTRL_RESET;
      regRdata <= 32'h00000000;
    end
    else
    begin
      if (regWr && regAddr == rsw_pkg::REG_CTRL)
        ctrl_r <= {30'h00000000, regWdata[1:0]};
      regRdata <= 32'h00000000;
      if (regRd)
      begin
        case (regAddr)
          rsw_pkg::REG_CTRL:   regRdata <= ctrl_r;
          rsw_pkg::REG_STATUS: regRdata <= {24'h000000, stallAlarm, errorFlag, terminalSelected_r,
                                            controlWordHere_r, wordEnable_r, state_r};
          rsw_pkg::REG_WORD:   regRdata <= {11'h000, shift_r};
          rsw_pkg::REG_RESP:   regRdata <= {13'h0000, response};
          default:             regRdata <= 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_phase_b_follows: assert property (@(posedge clk_sys) disable iff (!resetn)
    $fell(phaseAPulse) |-> phaseBPulse) else $error("phase B did not follow A");
  chk_word_here_set: assert property (@(posedge clk_sys) disable iff (!resetn)
    ($fell(wordEnable_r) && cdLvl_r && online) |-> controlWordHere_r) else $error("word-here not set");
  chk_err_resp_bit: assert property (@(posedge clk_sys) disable iff (!resetn)
    errorFlag |-> response[rsw_pkg::BIT_ERR]) else $error("error bit missing");
  chk_ready_gates_pha: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(phaseAPulse) |-> $past(selectedModuleReady)) else $error("phase A without ready");
  chk_mismatch_no_pha: assert property (@(posedge clk_sys) disable iff (!resetn)
    phaseAPulse |-> terminalSelected_r) else $error("phase A without select");
  chk_fib_word_enable: assert property (@(posedge clk_sys) disable iff (!resetn)
    firstBitFlag_r |-> wordEnable_r) else $error("word enable not set");
  chk_data_invert: assert property (@(posedge clk_sys) disable iff (!resetn)
    !manual && !$past(manual) |=> moduleDataOut == ~$past(shift_r[12:0])) else $error("data not inverted");
  chk_alarm_rearm: assert property (@(posedge clk_sys) disable iff (!resetn)
    alarmSet |=> !stallAlarm) else $error("alarm not rearmed");
endmodule

/* inc/rsw_pkg.sv */
// Purpose: Shared constants and types for the remote scanner word receiver
// Assumes: 50 MHz system clock
// Notes:   Word layout is start, 19 data bits, parity, two stop bits
package rsw_pkg;
  // Clock
  localparam int CLK_HZ         = 50000000;
  localparam int CLK_NS         = 20;
  // Times as printed, in nanoseconds except the alarm in milliseconds
  localparam int FIB_MAX_NS     = 1380;
  localparam int SEL_DELAY_NS   = 1300;
  localparam int PHASE_NS       = 20000;
  localparam int ALARM_MS       = 2000;
  // Cycle counts derived from the times
  localparam int FIB_MAX_CYC    = FIB_MAX_NS / CLK_NS;
  localparam int SEL_DELAY_CYC  = SEL_DELAY_NS / CLK_NS;
  localparam int PHASE_CYC      = (PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ALARM_CYC      = ALARM_MS * (CLK_HZ / 1000);
  // Word layout
  localparam int WORD_BITS      = 19;
  localparam int SHIFT_BITS     = 21;
  localparam int ADDR_LO        = 13;
  localparam int ADDR_HI        = 15;
  localparam int TERM_LO        = 16;
  localparam int TERM_HI        = 17;
  localparam int DATA_HI        = 12;
  localparam int BIT_SCE        = 10;
  localparam int BIT_COF        = 9;
  localparam int BIT_ERR        = 7;
  localparam int RDY_LO         = 16;
  localparam int CONV_LO        = 6;
  // Module address codes
  localparam logic [2:0] ADR_MO_SHORT = 3'h0;
  localparam logic [2:0] ADR_MO_LONG  = 3'h1;
  localparam logic [2:0] ADR_AO       = 3'h2;
  localparam logic [2:0] ADR_TO       = 3'h3;
  localparam logic [2:0] ADR_DI       = 3'h4;
  localparam logic [2:0] ADR_PBI      = 3'h5;
  localparam logic [2:0] ADR_ADI      = 3'h6;
  localparam logic [2:0] ADR_PBO      = 3'h7;
  // Register file
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_WORD   = 4'h8;
  localparam logic [3:0] REG_RESP   = 4'hC;
  localparam int CTRL_ONLINE  = 0;
  localparam int CTRL_MANUAL  = 1;
  localparam int CTRL_ALARM   = 2;
  localparam logic [31:0] CTRL_RESET = 32'h00000001;
  // Module status carrier
  typedef struct packed {
    logic        multiOutputReady;
    logic        deviceReady;
    logic        timedOutputReady;
    logic        scannerErrorOut;
    logic        converterOverflowOut;
    logic [11:0] converterData;
    logic [11:0] bufferData;
  } rsw_status_t;
  // Receive sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SHIFT = 3'b001,
    ST_CWH   = 3'b010,
    ST_WAIT  = 3'b011,
    ST_PHA   = 3'b100,
    ST_PHB   = 3'b101
  } rsw_state_t;
endpackage

/* test/rsw_line_model.sv */
// Purpose: Far-side model of the modem that feeds the scanner word receiver
// Assumes: One system clock; the bit cell is BIT_CYC clock cycles long
// Notes:   Carrier can be dropped in mid-frame to provoke a line error
`timescale 1ns/1ps
module rsw_line_model #(
  parameter int BIT_CYC = 16
) (
  // Clock
  input  wire logic clk_sys,
  // Modem lines
  output logic      lineIn,
  output logic      dataSetReadyIn,
  output logic      carrierOnIn,
  output logic      oscillatorTick
);
  logic [2:0] tickCnt_r;    // Divider for the oscillator tick

  // Line rests at mark with the data set up and carrier on
  initial
  begin
    lineIn         = 1'b1;
    dataSetReadyIn = 1'b1;
    carrierOnIn    = 1'b1;
    oscillatorTick = 1'b0;
    tickCnt_r      = 3'h0;
  end

  // One tick every eight cycles, well inside the first-bit deadline
  always @(posedge clk_sys)
  begin
    tickCnt_r      <= tickCnt_r + 3'h1;
    oscillatorTick <= (tickCnt_r == 3'h7);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Send start, 19 data bits LSB first, parity, two stops; cut > 0 drops carrier
  task automatic send_word(input logic [18:0] word, input logic badPar, input int cut);
    logic [22:0] frame;
    // start bit low, line returns to mark
    // Odd parity: data plus parity carry an odd count of ones
    frame = {2'b11, ~(^word) ^ badPar, word, 1'b0};
    for (int i = 0; i < 23; i++)
    begin
      @(posedge clk_sys);
      lineIn <= frame[i];
      // Carrier loss mid-word, the line error case
      if (cut != 0 && i == cut)
        carrierOnIn <= 1'b0;
      repeat (BIT_CYC - 1) @(posedge clk_sys);
    end
    carrierOnIn <= 1'b1;
  endtask
endmodule

/* test/test_rsw_receiver.sv */
// Purpose: Self-checking bench for the scanner word receiver
// Assumes: Short bit cell and short stall alarm to keep the run brief
// Notes:   Each word is followed by a settle time longer than both phases
`timescale 1ns/1ps
module test_rsw_receiver;
  localparam int BIT_CYC   = 16;     // Shortened bit cell
  localparam int ALARM_LEN = 200;    // Shortened stall alarm
  logic clk_sys, resetn, lineIn, dataSetReadyIn, carrierOnIn, oscillatorTick;
  logic conversionComplete, scannerConverting, regWr, regRd;
  logic phaseAPulse, phaseBPulse, simOutCmd, simInCmd, stallAlarm, errorFlag;
  logic [2:0]          moduleAddressBuffer;  // Loaded module address
  logic [12:0]         panelData, moduleDataOut;
  logic [3:0]          regAddr;
  logic [31:0]         regWdata, regRdata, rd;
  rsw_pkg::rsw_status_t moduleStatus;        // Module ready and data levels
  int failures, tests_run, cycles, aLen, bLen;
  logic outSeen, inSeen;                     // Command strobes seen in phase A

  rsw_receiver #(.BIT_CYC(BIT_CYC), .ALARM_LEN(ALARM_LEN), .TERM_ADDR(2'h0)) rsw_receiver_inst (
    .clk_sys(clk_sys), .resetn(resetn), .lineIn(lineIn), .dataSetReadyIn(dataSetReadyIn),
    .carrierOnIn(carrierOnIn), .oscillatorTick(oscillatorTick), .moduleStatus(moduleStatus),
    .conversionComplete(conversionComplete), .scannerConverting(scannerConverting),
    .panelData(panelData), .moduleAddressBuffer(moduleAddressBuffer), .moduleDataOut(moduleDataOut),
    .phaseAPulse(phaseAPulse), .phaseBPulse(phaseBPulse), .simOutCmd(simOutCmd), .simInCmd(simInCmd),
    .stallAlarm(stallAlarm), .errorFlag(errorFlag), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
  rsw_line_model #(.BIT_CYC(BIT_CYC)) rsw_line_model_inst (
    .clk_sys(clk_sys), .lineIn(lineIn), .dataSetReadyIn(dataSetReadyIn),
    .carrierOnIn(carrierOnIn), .oscillatorTick(oscillatorTick));

  // 50 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase lengths and command strobes; a timeout guards against a hang
  always @(posedge clk_sys)
  begin
    cycles = cycles + 1;
    if (phaseAPulse === 1'b1) aLen = aLen + 1;
    if (phaseBPulse === 1'b1) bLen = bLen + 1;
    if (phaseAPulse === 1'b1 && simOutCmd === 1'b1) outSeen = 1'b1;
    if (phaseAPulse === 1'b1 && simInCmd === 1'b1) inSeen = 1'b1;
    if (cycles == 40000)
    begin
      failures = failures + 1;
      $display("[ERR] %0t timeout", $time);
      tally_and_finish();
    end
  end

  // Compare with case equality so an unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Register write, one strobe cycle
  task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr    <= 1'b0;
  endtask

  // Register read; data stand only in the cycle after the strobe
  task automatic regRead(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd   <= 1'b0;
    @(posedge clk_sys);
    d = regRdata;
  endtask

  // Word layout: repeat, terminal, module address, data
  function automatic logic [18:0] mk(input logic [1:0] t, input logic [2:0] a, input logic [12:0] d);
    return {1'b0, t, a, d};
  endfunction

  // Clear the phase counters, then send one frame
  task automatic sendWord(input logic [18:0] w, input logic bad, input int cut);
    aLen = 0;
    bLen = 0;
    outSeen = 1'b0;
    inSeen = 1'b0;
    rsw_line_model_inst.send_word(w, bad, cut);
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    failures = 0; tests_run = 0; cycles = 0; aLen = 0; bLen = 0; outSeen = 0; inSeen = 0;
    resetn = 1'b0; regWr = 1'b0; regRd = 1'b0; regAddr = 4'h0; regWdata = 32'h00000000;
    conversionComplete = 1'b0; scannerConverting = 1'b0; panelData = 13'h0000;
    moduleStatus = '0;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    // Registers: reset value, unmapped place reads zero and ignores writes
    regRead(rsw_pkg::REG_CTRL, rd); chk(rd, rsw_pkg::CTRL_RESET, "ctrl reset");
    regWrite(4'h2, 32'hFFFFFFFF);
    regRead(4'h2, rd); chk(rd, 32'h00000000, "unmapped read");
    $display("test registers done");
    // Stall alarm: rearm, hold off, then let it run out
    regWrite(rsw_pkg::REG_CTRL, 32'h00000005);
    repeat (ALARM_LEN - 20) @(posedge clk_sys);
    chk(stallAlarm, 1'b0, "alarm early");
    repeat (60) @(posedge clk_sys);
    chk(stallAlarm, 1'b1, "alarm late");
    regWrite(rsw_pkg::REG_CTRL, 32'h00000005);
    repeat (3) @(posedge clk_sys);
    chk(stallAlarm, 1'b0, "alarm rearm");
    $display("test stall alarm done");
    // Good word to timed output, held back until the module is ready
    sendWord(mk(2'h0, rsw_pkg::ADR_TO, 13'h0A5C), 1'b0, 0);
    repeat (300) @(posedge clk_sys);
    chk(aLen, 0, "phase before ready");
    moduleStatus.timedOutputReady <= 1'b1;
    repeat (2500) @(posedge clk_sys);
    chk(aLen, rsw_pkg::PHASE_CYC, "phase A length");
    chk(bLen, rsw_pkg::PHASE_CYC, "phase B length");
    chk(moduleAddressBuffer, rsw_pkg::ADR_TO, "address load");
    chk(moduleDataOut, {19'h00000, ~13'h0A5C}, "data inverted");
    chk(outSeen, 1'b1, "output command");
    chk(errorFlag, 1'b0, "no error");
    $display("test dispatch done");
    // Digital input address gives an input command instead
    moduleStatus.deviceReady <= 1'b1;
    sendWord(mk(2'h0, rsw_pkg::ADR_DI, 13'h1FFF), 1'b0, 0);
    repeat (2500) @(posedge clk_sys);
    chk({inSeen, outSeen}, 2'b10, "input command");
    chk(moduleAddressBuffer, rsw_pkg::ADR_DI, "input address");
    $display("test input command done");
    // Data response: buffer bits with ready bits on top, then converter bits up to bit 17
    moduleStatus.bufferData <= 12'h5A3;
    regRead(rsw_pkg::REG_RESP, rd); chk(rd, 32'h000305A3, "buffer response");
    chk(rd[18:16], 3'b011, "ready bits");
    scannerConverting <= 1'b1;
    moduleStatus.converterData <= 12'hABC;
    regRead(rsw_pkg::REG_RESP, rd); chk(rd, 32'h0002AF00, "converter response");
    // Converting scanner: phase A waits for conversion complete
    sendWord(mk(2'h0, rsw_pkg::ADR_TO, 13'h0123), 1'b0, 0);
    repeat (300) @(posedge clk_sys);
    chk(aLen, 0, "phase before conversion");
    conversionComplete <= 1'b1;
    repeat (2500) @(posedge clk_sys);
    chk(aLen, rsw_pkg::PHASE_CYC, "phase A by AND path");
    scannerConverting <= 1'b0;
    conversionComplete <= 1'b0;
    $display("test converting done");
    // Even count of ones: error, with bit 07 in the response
    sendWord(mk(2'h0, rsw_pkg::ADR_TO, 13'h0001), 1'b1, 0);
    repeat (2500) @(posedge clk_sys);
    chk(errorFlag, 1'b1, "parity error");
    moduleStatus.scannerErrorOut <= 1'b1;
    regRead(rsw_pkg::REG_RESP, rd); chk(rd, 32'h00030480, "non-data response");
    regRead(rsw_pkg::REG_RESP, rd); chk(rd[rsw_pkg::BIT_ERR], 1'b1, "error bit");
    $display("test parity done");
    // Wrong terminal: reception abandoned
    sendWord(mk(2'h1, rsw_pkg::ADR_TO, 13'h0003), 1'b0, 0);
    repeat (2500) @(posedge clk_sys);
    chk(aLen, 0, "terminal mismatch");
    $display("test terminal done");
    // Carrier lost in mid-word
    sendWord(mk(2'h0, rsw_pkg::ADR_TO, 13'h0A5C), 1'b0, 8);
    repeat (2500) @(posedge clk_sys);
    chk(errorFlag, 1'b1, "carrier loss");
    chk(aLen, 0, "carrier loss no phase");
    $display("test carrier done");
    // Off line: the word never reaches a module
    regWrite(rsw_pkg::REG_CTRL, 32'h00000000);
    sendWord(mk(2'h0, rsw_pkg::ADR_TO, 13'h0A5C), 1'b0, 0);
    repeat (2500) @(posedge clk_sys);
    chk(aLen, 0, "off line");
    $display("test off line done");
    tally_and_finish();
  end
endmodule
